/* File: hdl/rms_sequencer.sv */
// Overview of operation
// RULE1 - Every command write stores bank address and pattern in the FIFO first; the code refuses a write while the FIFO is full.
// RULE2 - Acknowledge goes out once the command is stored, not after relays move.
// RULE3 - After the acknowledge, the bus side tells the drain side to start.
// RULE4 - While FIFO is not empty, pop entries and drive a 7 ms coil pulse each.
// RULE5 - One pulse drives a whole bank of up to 16 relays.
// RULE6 - Keep popping entries back to back until the FIFO is empty.
// RULE7 - Empty FIFO after the last pulse raises the interrupt request.
// RULE8 - Interrupt only once per complete list, never per relay.
// RULE9 - Reset, power-on and power-off never pulse the coils.
// RULE10 - After reset the commander must send commands that open every relay; the testbench opens banks 0 to 3 only.
// RULE11 - Bank pulses never overlap; at most one coil pulse at a time.
// RULE12 - Each entry pairs a bank select with a per-relay open/close pattern.
`timescale 1ns/1ps
module rms_sequencer
  import rms_pkg::*;
#(
  parameter int unsigned P_PULSE_CYCLES = COIL_PULSE_CYC,
  parameter int unsigned P_FIFO_DEPTH = FIFO_DEPTH
) (
  input wire logic i_clk_sys, // 50 MHz system clock
  input wire logic i_srst, // Synchronous reset, active high
  input wire logic i_cmd_wr, // Command write strobe
  input wire logic [BANK_W-1:0] i_cmd_bank, // Bank select address
  input wire logic [PATTERN_W-1:0] i_cmd_pattern, // Relay direction pattern
  output logic o_cmd_ready, // FIFO has room
  output logic o_cmd_ack, // Data acknowledge pulse
  output logic o_coil_pulse, // Coil drive active
  output logic [BANK_W-1:0] o_coil_bank, // Bank being driven
  output logic [PATTERN_W-1:0] o_coil_pattern, // Pattern being driven
  output logic o_irq, // Interrupt request, held
  input wire logic i_irq_ack // Commander clears the request
);
  localparam int unsigned ENTRY_W = BANK_W + PATTERN_W;

  initial begin
    if (P_PULSE_CYCLES < 1 || P_PULSE_CYCLES >= (1 << CNT_W)) begin
      $error("rms_sequencer pulse length out of counter range");
    end
  end

  typedef enum {ST_IDLE, ST_GAP, ST_DRIVE} rms_state_e;

  typedef struct packed {
    rms_state_e state;
    logic [CNT_W-1:0] cnt;
    logic ack;
    logic go;
    logic coil;
    logic [BANK_W-1:0] bank;
    logic [PATTERN_W-1:0] pattern;
    logic irq;
  } rms_seq_s;

  rms_seq_s st_r;
  rms_seq_s st_nxt;
  logic fifo_full;
  logic fifo_empty_n;
  logic fifo_pop;
  logic wr_take;
  logic [ENTRY_W-1:0] head;

  ////////////////////////////////////////////////////////////////////////////////
  // Command FIFO
  assign wr_take = i_cmd_wr && !fifo_full;
  assign o_cmd_ready = !fifo_full;

  rms_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(P_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_wr(i_cmd_wr), // [RULE1] [RULE12]
    .i_wr_data({i_cmd_bank, i_cmd_pattern}),
    .o_full(fifo_full),
    .i_rd(fifo_pop),
    .o_rd_data(head),
    .o_empty_n(fifo_empty_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    fifo_pop = 1'b0;
    st_nxt.ack = wr_take; // [RULE2]
    st_nxt.go = st_r.ack; // [RULE3]
    if (i_irq_ack) begin
      st_nxt.irq = 1'b0;
    end
    case (st_r.state)
      ST_IDLE: begin
        if (st_r.go) begin
          st_nxt.state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (fifo_empty_n) begin // [RULE4] [RULE6]
          fifo_pop = 1'b1;
          st_nxt.bank = head[ENTRY_W-1:PATTERN_W]; // [RULE12]
          st_nxt.pattern = head[PATTERN_W-1:0];
          st_nxt.cnt = CNT_W'(P_PULSE_CYCLES - 1);
          st_nxt.coil = 1'b1; // [RULE5]
          st_nxt.state = ST_DRIVE;
        end else begin
          st_nxt.irq = 1'b1; // [RULE7] [RULE8]
          st_nxt.state = ST_IDLE;
        end
      end
      ST_DRIVE: begin
        if (st_r.cnt == '0) begin
          st_nxt.coil = 1'b0; // [RULE11]
          st_nxt.state = ST_GAP;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
        st_nxt.coil = 1'b0;
      end
    endcase
  end

  // Reset leaves the coils idle so relays keep their positions
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r <= '{state: ST_IDLE, default: '0}; // [RULE9]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs from the state flops
  assign o_cmd_ack = st_r.ack;
  assign o_coil_pulse = st_r.coil;
  assign o_coil_bank = st_r.bank;
  assign o_coil_pattern = st_r.pattern;
  assign o_irq = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_write_taken;
    i_cmd_wr && o_cmd_ready;
  endsequence

  sequence s_coil_start;
    !o_coil_pulse ##1 o_coil_pulse;
  endsequence

  a_ack_after_store: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE2]
    s_write_taken |=> o_cmd_ack)
    else $error("acknowledge missing after stored write");

  a_store_fifo_fill: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE1]
    s_write_taken |=> fifo_empty_n || o_coil_pulse)
    else $error("written command not held");

  a_go_after_ack: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE3]
    o_cmd_ack |=> st_r.go)
    else $error("start not signalled after acknowledge");

  a_pulse_length: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE4]
    s_coil_start |-> (st_r.cnt == CNT_W'(P_PULSE_CYCLES - 1)))
    else $error("coil pulse started with wrong length");

  a_pulse_end: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE11]
    o_coil_pulse && st_r.cnt == '0 |=> !o_coil_pulse)
    else $error("coil pulse did not end");

  a_bank_steady: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE5]
    o_coil_pulse && $past(o_coil_pulse) |-> $stable(o_coil_bank) && $stable(o_coil_pattern))
    else $error("bank changed during pulse");

  a_drain_next: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE6]
    o_coil_pulse && st_r.cnt == '0 ##1 fifo_empty_n |=> o_coil_pulse)
    else $error("next entry not drained");

  a_irq_when_empty: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE7]
    st_r.state == ST_GAP && !fifo_empty_n |=> o_irq)
    else $error("interrupt missing after list end");

  a_irq_once: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE8]
    $rose(o_irq) |-> !o_coil_pulse && !$past(fifo_empty_n))
    else $error("interrupt raised inside a list");

  a_reset_quiet: assert property (@(posedge i_clk_sys) // [RULE9]
    i_srst |=> !o_coil_pulse)
    else $error("coil driven after reset");

  a_reset_no_irq: assert property (@(posedge i_clk_sys) // [RULE9]
    i_srst |=> !o_irq && !o_cmd_ack)
    else $error("request or acknowledge left after reset");

  // A write refused for lack of room must never look stored
  a_refuse_no_ack: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE2]
    i_cmd_wr && !o_cmd_ready |=> !o_cmd_ack)
    else $error("acknowledge for a refused write");

  // Only the drive phase may power a coil, so two banks never overlap
  a_coil_drive_only: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE11]
    o_coil_pulse == (st_r.state == ST_DRIVE))
    else $error("coil level and drive phase disagree");

  a_pop_gap_only: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE11]
    st_r.state != ST_GAP |-> !fifo_pop)
    else $error("entry popped while a bank is driven");

  // The popped entry is the one that reaches the coil outputs
  a_entry_to_coil: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE12]
    fifo_pop |=> o_coil_pulse && ({o_coil_bank, o_coil_pattern} == $past(head)))
    else $error("coil word differs from popped entry");

  // Interrupt request steps: list end sets it, commander clears it
  sequence s_list_end;
    st_r.state == ST_GAP && !fifo_empty_n;
  endsequence

  sequence s_irq_cleared;
    i_irq_ack && !(st_r.state == ST_GAP && !fifo_empty_n);
  endsequence

  a_irq_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE7]
    s_irq_cleared |=> !o_irq)
    else $error("interrupt not cleared by commander");

  a_irq_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE7]
    o_irq && !i_irq_ack |=> o_irq)
    else $error("interrupt dropped without clear");

  // A clear in the same cycle as a list end must not lose the request
  a_irq_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_srst) // [RULE7]
    i_irq_ack ##0 s_list_end |=> o_irq)
    else $error("list end interrupt lost to a clear");
endmodule : rms_sequencer

/* File: hdl/rms_fifo.sv */
`timescale 1ns/1ps
package rms_pkg;
  // System clock rate and coil pulse length
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned COIL_PULSE_MS = 7;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned COIL_PULSE_CYC = (COIL_PULSE_MS * CLK_HZ) / MS_PER_S;
  // Command word layout, FIFO depth and pulse counter width
  localparam int unsigned BANK_W = 8;
  localparam int unsigned PATTERN_W = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W = 20;
endpackage : rms_pkg

module rms_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_srst, // Synchronous reset
  input wire logic i_wr, // Write strobe
  input wire logic [WIDTH-1:0] i_wr_data, // Write word
  output logic o_full, // No room left
  input wire logic i_rd, // Pop strobe
  output logic [WIDTH-1:0] o_rd_data, // Head word
  output logic o_empty_n // Entries present, active low empty
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("rms_fifo depth must be a power of two, at least 2");
    end
  end

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } rms_fifo_s;

  rms_fifo_s st_r;
  rms_fifo_s st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  // Status flags from the pointers
  assign o_empty_n = (st_r.wr_ptr != st_r.rd_ptr);
  assign o_full = (st_r.wr_ptr[AW-1:0] == st_r.rd_ptr[AW-1:0]) && (st_r.wr_ptr[AW] != st_r.rd_ptr[AW]);
  assign do_wr = i_wr && !o_full;
  assign do_rd = i_rd && o_empty_n;
  assign o_rd_data = mem[st_r.rd_ptr[AW-1:0]];

  // Pointer update
  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage array
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[st_r.wr_ptr[AW-1:0]] <= i_wr_data;
    end
  end
endmodule : rms_fifo

/* File: sim/rms_commander.sv */
`timescale 1ns/1ps
module rms_commander
  import rms_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_cmd_ready, // Card has room
  input wire logic i_irq, // Card interrupt request
  output logic o_cmd_wr, // Write strobe
  output logic [BANK_W-1:0] o_cmd_bank, // Bank select
  output logic [PATTERN_W-1:0] o_cmd_pattern, // Relay pattern
  output logic o_irq_ack // Interrupt clear
);
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_bank = '0;
    o_cmd_pattern = '0;
    o_irq_ack = 1'b0;
  end
  // Hold one command until taken, then go on without waiting for the relays
  task automatic send(input logic [BANK_W-1:0] b, input logic [PATTERN_W-1:0] p);
    o_cmd_wr <= 1'b1;
    o_cmd_bank <= b;
    o_cmd_pattern <= p;
    do @(posedge i_clk_sys); while (!i_cmd_ready);
  endtask : send
  // Drop the strobe; data lines stop showing the last word
  task automatic release_bus();
    o_cmd_wr <= 1'b0;
    o_cmd_bank <= ~o_cmd_bank;
    o_cmd_pattern <= ~o_cmd_pattern;
  endtask : release_bus
  // Open every relay of banks 0 to n_banks-1, since reset leaves them as they were
  task automatic open_all(input int n_banks);
    for (int i = 0; i < n_banks; i++) begin
      send(i[BANK_W-1:0], '0);
    end
    release_bus();
  endtask : open_all
  // Clear the interrupt one cycle after it shows
  always @(posedge i_clk_sys) begin
    o_irq_ack <= i_irq && !o_irq_ack;
  end
endmodule : rms_commander

/* File: sim/test_relay_matrix_command_sequencer.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_relay_matrix_command_sequencer
  import rms_pkg::*;
;
  localparam int unsigned PULSE = 8;
  logic i_clk_sys, i_srst, wr, ready, ack, coil, irq, irq_ack;
  logic [BANK_W-1:0] bank, coil_bank;
  logic [PATTERN_W-1:0] pat, coil_pat;
  logic [BANK_W+PATTERN_W-1:0] expq[$];
  logic [BANK_W+PATTERN_W-1:0] head;
  int err_count = 0, n_tests = 0, irq_rises = 0, lists = 0, hi_cnt = 0;
  logic prev_taken = 1'b0, prev_coil = 1'b0, prev_irq = 1'b0, prev_irq_ack = 1'b0;
  // Room is expected while fewer words wait than the FIFO holds
  function automatic logic exp_ready(input int occ);
    return occ < FIFO_DEPTH;
  endfunction : exp_ready
  rms_sequencer #(.P_PULSE_CYCLES(PULSE)) i_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cmd_wr(wr),
    .i_cmd_bank(bank), .i_cmd_pattern(pat), .o_cmd_ready(ready), .o_cmd_ack(ack), .o_coil_pulse(coil),
    .o_coil_bank(coil_bank), .o_coil_pattern(coil_pat), .o_irq(irq), .i_irq_ack(irq_ack));
  rms_commander i_cmdr (.i_clk_sys(i_clk_sys), .i_cmd_ready(ready), .i_irq(irq), .o_cmd_wr(wr),
    .o_cmd_bank(bank), .o_cmd_pattern(pat), .o_irq_ack(irq_ack));
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // Verdict and end of run
  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // Port monitor: stored words, acknowledge timing, pulses and interrupts
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      prev_taken = 1'b0;
      `CHK("coil in reset", 1'b0, coil)
    end else begin
      `CHK("ack", prev_taken, ack)
      if (coil && !prev_coil) begin
        head = (expq.size() > 0) ? expq.pop_front() : 'x;
        `CHK("coil word", head, {coil_bank, coil_pat})
      end
      `CHK("ready", exp_ready(expq.size()), ready)
      if (prev_irq_ack) `CHK("irq cleared", 1'b0, irq)
      prev_taken = wr && ready;
      if (prev_taken) expq.push_back({bank, pat});
      if (!coil && prev_coil) `CHK("pulse length", PULSE, hi_cnt)
      hi_cnt = coil ? hi_cnt + 1 : 0;
      if (irq && !prev_irq) irq_rises++;
    end
    prev_coil = coil;
    prev_irq = irq;
    prev_irq_ack = irq_ack;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Wait until one list has drained and its interrupt has come
  task automatic drain();
    lists++;
    for (int i = 0; i < 400 && !(expq.size() == 0 && irq_rises == lists && !coil); i++) begin
      @(posedge i_clk_sys);
    end
    repeat (4) @(posedge i_clk_sys);
    `CHK("irq count", lists, irq_rises)
    `CHK("queue left", 0, expq.size())
  endtask : drain
  // Main sequence: open banks 0 to 3, a full-FIFO list, then random lists
  initial begin
    int n;
    i_srst = 1'b1;
    void'($urandom(32'hd93b_e882));
    repeat (8) @(posedge i_clk_sys);
    `CHK("coil after reset", 1'b0, coil)
    `CHK("irq after reset", 1'b0, irq)
    i_srst <= 1'b0;
    @(posedge i_clk_sys);
    i_cmdr.open_all(4);
    drain();
    for (int l = 0; l < 12; l++) begin
      n = (l == 0) ? 20 : 1 + ($urandom % 6);
      for (int k = 0; k < n; k++) begin
        i_cmdr.send(BANK_W'($urandom), (k == 1) ? 16'hffff : PATTERN_W'($urandom));
      end
      i_cmdr.release_bus();
      drain();
    end
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule : test_relay_matrix_command_sequencer
